// [rtl/rsdc_reset_config.sv]
`timescale 1ns/1ps
module rsdc_reset_config
    import rsdc_pkg::*;
(
    // clock (bypassed reference oscillator) and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // reset sources
    input wire logic i_ext_reset_pin_n,
    input wire logic i_test_reset_n,
    input wire logic i_watchdog_timer_req,
    input wire logic i_emu_max_req,
    input wire logic i_emu_sys_req,
    input wire logic [51:0] i_sw_module_reset,
    // strap pins
    input wire logic [2:0] i_boot_source_strap_pin,
    input wire logic [2:0] i_ext_mem_pin_strap_pin,
    input wire logic i_osc_range_strap_pin,
    // reset outputs
    output logic o_por_reset,
    output logic o_warm_reset,
    output logic o_sys_reset,
    output logic [51:0] o_module_reset,
    output rsdc_rst_e o_last_reset,
    // latched straps and derived configuration
    output logic o_strap_sampling,
    output logic [2:0] o_boot_source_strap,
    output logic [2:0] o_ext_mem_pin_strap,
    output logic o_osc_range_strap,
    output logic o_mem_wide,
    output logic o_pll1_enable,
    output logic o_pll2_enable,
    output logic o_pll_bypass,
    output logic [51:0] o_module_enable,
    output logic [31:0] o_boot_entry,
    // memory pin roles
    output logic [15:0] o_addr_pin_is_mem,
    output logic o_top_pin_is_a14,
    output logic [7:0] o_hi_data_is_mem,
    output logic [6:0] o_upper_addr_is_mem,
    output logic [1:0] o_byte_addr_lsb_sel,
    // wait-state defaults
    output logic [4:0] o_setup_cycles,
    output logic [6:0] o_strobe_cycles,
    output logic [3:0] o_hold_cycles
);
    logic cold_req;
    logic warm_req;
    logic max_req;
    logic full_req;
    logic full_q;
    logic sampled_q;
    logic [2:0] boot_q;
    logic [2:0] memcfg_q;
    logic osc_q;
    logic [51:0] enable_d;
    logic [51:0] enable_q;
    logic [15:0] addr_map;
    logic top_a14;
    logic [7:0] hi_map;

    // cold request
    // both pins low means cold; the test reset alone starts nothing here
    assign cold_req = !i_ext_reset_pin_n && !i_test_reset_n;
    assign warm_req = !i_ext_reset_pin_n && i_test_reset_n;
    assign max_req = i_watchdog_timer_req || i_emu_max_req;
    assign full_req = cold_req || warm_req || max_req;

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_por_reset <= 1'b1;
        end else begin
            o_por_reset <= cold_req;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_warm_reset <= 1'b1;
        end else begin
            o_warm_reset <= full_req;
        end
    end

    // soft reset; memory, clocks and power untouched
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sys_reset <= 1'b0;
        end else begin
            // a full reset swallows a system request arriving with it
            o_sys_reset <= i_emu_sys_req && !full_req;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_last_reset <= RSDC_RST_POR;
        end else if (cold_req) begin
            o_last_reset <= RSDC_RST_POR;
        end else if (warm_req) begin
            o_last_reset <= RSDC_RST_WARM;
        end else if (max_req) begin
            o_last_reset <= RSDC_RST_MAX;
        end else if (i_emu_sys_req) begin
            o_last_reset <= RSDC_RST_SYS;
        end
        // with no request the kind holds until the next one
    end

    // per-module software reset, also held by full resets
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_module_reset <= {RSDC_NUM_MODULES{1'b1}};
        end else begin
            o_module_reset <= i_sw_module_reset | {RSDC_NUM_MODULES{full_q}};
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            full_q <= 1'b1;
        end else begin
            full_q <= full_req;
        end
    end

    // sampling window open while a full reset stands
    assign o_strap_sampling = !sampled_q;

    // capture on the first edge after release; reset holds a constant
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sampled_q <= 1'b0;
        end else if (full_req) begin
            // reopened by every full reset, so a warm reset reads the pins again
            sampled_q <= 1'b0;
        end else begin
            sampled_q <= 1'b1;
        end
    end

    // latched straps; system reset leaves them
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            boot_q <= RSDC_BOOT_RST;
            memcfg_q <= RSDC_MEMCFG_RST;
            osc_q <= RSDC_OSC_RST;
        end else if (!sampled_q && !full_req) begin
            // system reset is deliberately absent from this condition
            boot_q <= i_boot_source_strap_pin;
            memcfg_q <= i_ext_mem_pin_strap_pin;
            osc_q <= i_osc_range_strap_pin;
        end
    end

    assign o_boot_source_strap = boot_q;
    assign o_ext_mem_pin_strap = memcfg_q;
    // 0 = 15-35 MHz range, 1 = 30-40 MHz range
    assign o_osc_range_strap = osc_q;
    assign o_mem_wide = memcfg_q[RSDC_MEMCFG_WIDE_BIT];

    // PLLs off and bypassed after full resets, register defaults
    // these are the reset images of pll control kept elsewhere
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pll1_enable <= 1'b0;
            o_pll2_enable <= 1'b0;
            o_pll_bypass <= 1'b1;
        end else if (full_req) begin
            o_pll1_enable <= 1'b0;
            o_pll2_enable <= 1'b0;
            o_pll_bypass <= 1'b1;
        end
    end

    always_comb begin
        enable_d = {RSDC_NUM_MODULES{1'b0}};
        enable_d[RSDC_MOD_TIMER0] = 1'b1;
        enable_d[RSDC_MOD_TIMER2] = 1'b1;
        enable_d[RSDC_MOD_SYSTEM] = 1'b1;
        enable_d[RSDC_MOD_CPU] = 1'b1;
        enable_d[RSDC_MOD_RSVD34] = 1'b1;
        enable_d[RSDC_MOD_EMU] = 1'b1;
        enable_d[RSDC_MOD_RTC] = 1'b1;
        case (rsdc_boot_e'(boot_q))
            RSDC_BOOT_NAND, RSDC_BOOT_ASYNC: begin
                enable_d[RSDC_MOD_DMA_CC] = 1'b1;
                enable_d[RSDC_MOD_DMA_TC0] = 1'b1;
                enable_d[RSDC_MOD_ASYNC_IF] = 1'b1;
            end
            RSDC_BOOT_SD: begin
                enable_d[RSDC_MOD_SD0] = 1'b1;
            end
            RSDC_BOOT_UART: begin
                enable_d[RSDC_MOD_UART0] = 1'b1;
            end
            RSDC_BOOT_USB: begin
                enable_d[RSDC_MOD_DMA_CC] = 1'b1;
                enable_d[RSDC_MOD_DMA_TC0] = 1'b1;
                enable_d[RSDC_MOD_USB] = 1'b1;
            end
            RSDC_BOOT_SPI: begin
                enable_d[RSDC_MOD_SPI0] = 1'b1;
            end
            RSDC_BOOT_ETH: begin
                enable_d[RSDC_MOD_DMA_CC] = 1'b1;
                enable_d[RSDC_MOD_DMA_TC0] = 1'b1;
                enable_d[RSDC_MOD_ETH] = 1'b1;
            end
            RSDC_BOOT_HOST: begin
                enable_d[RSDC_MOD_HOST] = 1'b1;
            end
            default: begin
                enable_d[RSDC_MOD_ASYNC_IF] = 1'b1;
            end
        endcase
    end

    // enables reload only after the straps are fresh; then they follow the latched boot strap every cycle
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            enable_q <= {RSDC_NUM_MODULES{1'b0}};
        end else if (!sampled_q) begin
            // zero while sampling so no boot peripheral starts on stale straps
            enable_q <= {RSDC_NUM_MODULES{1'b0}};
        end else begin
            enable_q <= enable_d;
        end
    end
    assign o_module_enable = enable_q;

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_boot_entry <= RSDC_ROM_ENTRY;
        end else if (boot_q == RSDC_BOOT_ASYNC) begin
            // follows the latched mode, so it is constant between full resets
            o_boot_entry <= RSDC_FLASH_ENTRY;
        end else begin
            o_boot_entry <= RSDC_ROM_ENTRY;
        end
    end

    // pin roles from the latched strap
    rsdc_pin_map u_pin_map (
        .i_ext_mem_pin_strap(memcfg_q),
        .o_addr_pin_is_mem(addr_map),
        .o_hi_data_is_mem(hi_map),
        .o_top_pin_is_a14(top_a14)
    );

    // straps own the pins until sampled; then general I/O where unused
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_addr_pin_is_mem <= 16'h0000;
            o_hi_data_is_mem <= 8'h00;
            o_top_pin_is_a14 <= 1'b0;
        end else if (!sampled_q) begin
            // released one edge after capture, never while the straps are read
            o_addr_pin_is_mem <= 16'h0000;
            o_hi_data_is_mem <= 8'h00;
            o_top_pin_is_a14 <= 1'b0;
        end else begin
            o_addr_pin_is_mem <= addr_map;
            o_hi_data_is_mem <= hi_map;
            o_top_pin_is_a14 <= top_a14;
        end
    end

    // upper address pins stay general I/O out of reset
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_upper_addr_is_mem <= 7'h00;
        end else if (full_req) begin
            // only software remaps these later; the board holds them low meanwhile
            o_upper_addr_is_mem <= 7'h00;
        end
    end

    // byte pins: wide = {a14, halfword lsb}, narrow = {a1, a0}
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_byte_addr_lsb_sel <= 2'b00;
        end else if (!sampled_q) begin
            o_byte_addr_lsb_sel <= 2'b00;
        end else begin
            o_byte_addr_lsb_sel <= {2{memcfg_q[RSDC_MEMCFG_WIDE_BIT]}};
        end
    end

    // slowest wait states when interface enabled; strap not involved
    // no software write path lives here, so the values only reload
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_setup_cycles <= RSDC_SETUP_RST;
            o_strobe_cycles <= RSDC_STROBE_RST;
            o_hold_cycles <= RSDC_HOLD_RST;
        end else if (full_req) begin
            o_setup_cycles <= RSDC_SETUP_RST;
            o_strobe_cycles <= RSDC_STROBE_RST;
            o_hold_cycles <= RSDC_HOLD_RST;
        end
    end
endmodule // rsdc_reset_config

// [rtl/rsdc_pkg.sv]
package rsdc_pkg;
    // boot source codes
    typedef enum logic [2:0] {
        RSDC_BOOT_NAND = 3'h0,
        RSDC_BOOT_ASYNC = 3'h1,
        RSDC_BOOT_SD = 3'h2,
        RSDC_BOOT_UART = 3'h3,
        RSDC_BOOT_USB = 3'h4,
        RSDC_BOOT_SPI = 3'h5,
        RSDC_BOOT_ETH = 3'h6,
        RSDC_BOOT_HOST = 3'h7
    } rsdc_boot_e;

    // reset kinds reported to the rest of the chip
    typedef enum logic [2:0] {
        RSDC_RST_NONE = 3'h0,
        RSDC_RST_POR = 3'h1,
        RSDC_RST_WARM = 3'h2,
        RSDC_RST_MAX = 3'h3,
        RSDC_RST_SYS = 3'h4
    } rsdc_rst_e;

    localparam int RSDC_NUM_MODULES = 52;
    localparam logic [2:0] RSDC_BOOT_RST = 3'h0;
    localparam logic [2:0] RSDC_MEMCFG_RST = 3'h0;
    localparam logic RSDC_OSC_RST = 1'b0;
    localparam int RSDC_MEMCFG_WIDE_BIT = 2;

    // module slot numbers
    localparam int RSDC_MOD_DMA_CC = 0;
    localparam int RSDC_MOD_DMA_TC0 = 1;
    localparam int RSDC_MOD_USB = 9;
    localparam int RSDC_MOD_ASYNC_IF = 14;
    localparam int RSDC_MOD_SD0 = 15;
    localparam int RSDC_MOD_UART0 = 19;
    localparam int RSDC_MOD_HOST = 21;
    localparam int RSDC_MOD_SPI0 = 22;
    localparam int RSDC_MOD_TIMER0 = 27;
    localparam int RSDC_MOD_TIMER2 = 29;
    localparam int RSDC_MOD_SYSTEM = 30;
    localparam int RSDC_MOD_CPU = 31;
    localparam int RSDC_MOD_RSVD34 = 34;
    localparam int RSDC_MOD_EMU = 35;
    localparam int RSDC_MOD_ETH = 40;
    localparam int RSDC_MOD_RTC = 41;

    // boot entry points
    localparam logic [31:0] RSDC_ROM_ENTRY = 32'h0000_8000;
    localparam logic [31:0] RSDC_FLASH_ENTRY = 32'h0200_0000;

    // wait-state defaults, in interface cycles
    localparam logic [4:0] RSDC_SETUP_RST = 5'h10;
    localparam logic [6:0] RSDC_STROBE_RST = 7'h40;
    localparam logic [3:0] RSDC_HOLD_RST = 4'h8;

    // pin-role counts
    localparam int RSDC_ADDR_PINS = 16;
    localparam int RSDC_UPPER_PINS = 7;
    localparam int RSDC_HI_DATA_PINS = 8;
endpackage

// [rtl/rsdc_pin_map.sv]
`timescale 1ns/1ps
module rsdc_pin_map
    import rsdc_pkg::*;
(
    // latched strap
    input wire logic [2:0] i_ext_mem_pin_strap,
    // pin roles, one bit per pin, 1 = memory interface function
    output logic [15:0] o_addr_pin_is_mem,
    output logic [7:0] o_hi_data_is_mem,
    output logic o_top_pin_is_a14
);
    // pin order: 0 top pin, 1 byte addr 1, 2 addr 0, 3..15 addr 1..13
    always_comb begin
        o_addr_pin_is_mem = 16'h0000;
        o_top_pin_is_a14 = 1'b0;
        case (i_ext_mem_pin_strap[1:0])
            2'b00: begin
                o_addr_pin_is_mem = 16'h0018;
            end
            2'b01: begin
                o_addr_pin_is_mem = 16'hffff;
                o_top_pin_is_a14 = 1'b1;
            end
            2'b10: begin
                o_addr_pin_is_mem = 16'hffff;
            end
            default: begin
                o_addr_pin_is_mem = 16'h0000;
            end
        endcase
    end

    // upper data lanes only for wide codes
    assign o_hi_data_is_mem = {8{i_ext_mem_pin_strap[RSDC_MEMCFG_WIDE_BIT]}};
endmodule // rsdc_pin_map

// [verification/rsdc_board_model.sv]
`timescale 1ns/1ps
module rsdc_board_model (
    // clock and pin ownership
    input wire logic i_clock,
    input wire logic i_sampling,
    // strap levels wanted
    input wire logic [2:0] i_boot_want,
    input wire logic [2:0] i_mem_want,
    input wire logic i_osc_want,
    // shared pins
    output logic [2:0] o_boot_pin,
    output logic [2:0] o_mem_pin,
    output logic o_osc_pin,
    // upper address pins as the board leaves them
    output logic [6:0] o_upper_pin
);
    logic tog_q = 1'b0;

    always_ff @(posedge i_clock) begin
        tog_q <= ~tog_q;
    end
    // pins driven by memory bus after sampling, so the levels keep moving
    assign o_boot_pin = i_sampling ? i_boot_want : ~i_boot_want ^ {3{tog_q}};
    assign o_mem_pin = i_sampling ? i_mem_want : ~i_mem_want ^ {3{tog_q}};
    // board sets this once and holds it
    assign o_osc_pin = i_osc_want;
    // board pulls upper address pins low
    assign o_upper_pin = 7'h00;
endmodule // rsdc_board_model

// [verification/rsdc_reset_config_sva.sv]
`timescale 1ns/1ps
module rsdc_reset_config_chk
    import rsdc_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_ext_reset_pin_n,
    input wire logic i_test_reset_n,
    input wire logic i_watchdog_timer_req,
    input wire logic i_emu_max_req,
    input wire logic i_emu_sys_req,
    input wire logic [2:0] i_boot_source_strap_pin,
    input wire logic [2:0] i_ext_mem_pin_strap_pin,
    input wire logic i_osc_range_strap_pin,
    input wire logic o_por_reset,
    input wire logic o_warm_reset,
    input wire logic o_sys_reset,
    input wire logic o_strap_sampling,
    input wire logic [2:0] o_boot_source_strap,
    input wire logic [2:0] o_ext_mem_pin_strap,
    input wire logic o_osc_range_strap,
    input wire logic o_mem_wide,
    input wire logic [51:0] o_module_enable,
    input wire logic [31:0] o_boot_entry,
    input wire logic [7:0] o_hi_data_is_mem,
    input wire logic [4:0] o_setup_cycles,
    input wire logic [6:0] o_strobe_cycles,
    input wire logic [3:0] o_hold_cycles
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    a_cold_reset: assert property (!i_ext_reset_pin_n && !i_test_reset_n |=> o_por_reset && o_warm_reset)
        else $error("cold request gave no cold reset");
    a_warm_only: assert property (!i_ext_reset_pin_n && i_test_reset_n |=> !o_por_reset && o_warm_reset)
        else $error("warm request reset test logic or nothing");
    a_max_as_warm: assert property ((i_watchdog_timer_req || i_emu_max_req) && i_ext_reset_pin_n
        |=> o_warm_reset && !o_por_reset) else $error("max request not treated as warm");
    a_sys_soft: assert property (i_emu_sys_req && i_ext_reset_pin_n && !i_watchdog_timer_req
        && !i_emu_max_req && !o_warm_reset |=> o_sys_reset) else $error("system reset missing");
    a_strap_capture: assert property (o_strap_sampling && i_ext_reset_pin_n && !i_watchdog_timer_req
        && !i_emu_max_req |=> !o_strap_sampling && o_boot_source_strap == $past(i_boot_source_strap_pin)
        && o_ext_mem_pin_strap == $past(i_ext_mem_pin_strap_pin)
        && o_osc_range_strap == $past(i_osc_range_strap_pin)) else $error("straps not captured");
    a_straps_hold: assert property (!o_strap_sampling |=> $stable(o_boot_source_strap)
        && $stable(o_ext_mem_pin_strap) && $stable(o_osc_range_strap)) else $error("strap moved");
    a_boot_entry: assert property (!o_strap_sampling [*2] |-> o_boot_entry ==
        (o_boot_source_strap == 3'h1 ? RSDC_FLASH_ENTRY : RSDC_ROM_ENTRY)) else $error("bad entry");
    a_fixed_enables: assert property (!o_strap_sampling [*2] |-> o_module_enable[27]
        && o_module_enable[29] && o_module_enable[30] && o_module_enable[31]
        && o_module_enable[34] && o_module_enable[35] && o_module_enable[41])
        else $error("fixed module not enabled");
    a_hi_data_role: assert property (!o_strap_sampling [*2] |-> o_mem_wide == o_ext_mem_pin_strap[2]
        && o_hi_data_is_mem == {8{o_ext_mem_pin_strap[2]}}) else $error("data width roles wrong");
    a_slow_waits: assert property (o_setup_cycles == RSDC_SETUP_RST
        && o_strobe_cycles == RSDC_STROBE_RST && o_hold_cycles == RSDC_HOLD_RST)
        else $error("wait states not slowest");

    c_capture: cover property ($fell(o_strap_sampling));
    c_sys: cover property (o_sys_reset);
    c_cold: cover property (o_por_reset && i_ext_reset_pin_n);
endmodule // rsdc_reset_config_chk

bind rsdc_reset_config rsdc_reset_config_chk i_chk (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_ext_reset_pin_n(i_ext_reset_pin_n), .i_test_reset_n(i_test_reset_n),
    .i_watchdog_timer_req(i_watchdog_timer_req), .i_emu_max_req(i_emu_max_req),
    .i_emu_sys_req(i_emu_sys_req), .i_boot_source_strap_pin(i_boot_source_strap_pin),
    .i_ext_mem_pin_strap_pin(i_ext_mem_pin_strap_pin), .i_osc_range_strap_pin(i_osc_range_strap_pin),
    .o_por_reset(o_por_reset), .o_warm_reset(o_warm_reset), .o_sys_reset(o_sys_reset),
    .o_strap_sampling(o_strap_sampling), .o_boot_source_strap(o_boot_source_strap),
    .o_ext_mem_pin_strap(o_ext_mem_pin_strap), .o_osc_range_strap(o_osc_range_strap),
    .o_mem_wide(o_mem_wide), .o_module_enable(o_module_enable), .o_boot_entry(o_boot_entry),
    .o_hi_data_is_mem(o_hi_data_is_mem), .o_setup_cycles(o_setup_cycles),
    .o_strobe_cycles(o_strobe_cycles), .o_hold_cycles(o_hold_cycles));

// [verification/tb_reset_strap_default_config.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; \
    $display("[ERR] %0t mismatch got %h exp %h", $time, (a), (b)); end end
module tb_reset_strap_default_config
    import rsdc_pkg::*;
;
    typedef struct {logic [2:0] b; logic [2:0] m; rsdc_rst_e k; logic [51:0] sw;} rsdc_note_s;
    logic i_clock = 1'b0, i_rst_n = 1'b0, ext_n = 1'b1, test_n = 1'b1, wd = 1'b0, emax = 1'b0;
    logic esys = 1'b0, osc = 1'b0, samp_q = 1'b1;
    logic [2:0] want_b = 3'h0, want_m = 3'h0, b_pin, m_pin;
    logic osc_pin;
    logic [6:0] up_pin;
    logic [51:0] sw = '0;
    int err_total = 0, samples_checked = 0, seed = 32'h3167_c0c1;
    rsdc_note_s q[$];
    rsdc_note_s n;
    logic por, warm, sys, samp, wide, a14, pl1, pl2, byp, osc_q;
    logic [51:0] mrst, en;
    rsdc_rst_e last;
    logic [2:0] bs, ms;
    logic [31:0] entry;
    logic [15:0] apin;
    logic [7:0] hid;
    logic [6:0] upr, stb;
    logic [1:0] bsel;
    logic [4:0] setup;
    logic [3:0] hold;

    always #20 i_clock = ~i_clock;

    rsdc_board_model i_board (.i_clock(i_clock), .i_sampling(samp), .i_boot_want(want_b),
        .i_mem_want(want_m), .i_osc_want(osc), .o_boot_pin(b_pin), .o_mem_pin(m_pin),
        .o_osc_pin(osc_pin), .o_upper_pin(up_pin));
    rsdc_reset_config i_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_ext_reset_pin_n(ext_n),
        .i_test_reset_n(test_n), .i_watchdog_timer_req(wd), .i_emu_max_req(emax),
        .i_emu_sys_req(esys), .i_sw_module_reset(sw), .i_boot_source_strap_pin(b_pin),
        .i_ext_mem_pin_strap_pin(m_pin), .i_osc_range_strap_pin(osc_pin), .o_por_reset(por),
        .o_warm_reset(warm), .o_sys_reset(sys), .o_module_reset(mrst), .o_last_reset(last),
        .o_strap_sampling(samp), .o_boot_source_strap(bs), .o_ext_mem_pin_strap(ms),
        .o_osc_range_strap(osc_q), .o_mem_wide(wide), .o_pll1_enable(pl1), .o_pll2_enable(pl2),
        .o_pll_bypass(byp), .o_module_enable(en), .o_boot_entry(entry), .o_addr_pin_is_mem(apin),
        .o_top_pin_is_a14(a14), .o_hi_data_is_mem(hid), .o_upper_addr_is_mem(upr),
        .o_byte_addr_lsb_sel(bsel), .o_setup_cycles(setup), .o_strobe_cycles(stb),
        .o_hold_cycles(hold));

    function automatic logic [51:0] exp_en(input logic [2:0] b);
        logic [51:0] e;
        e = '0;
        e[RSDC_MOD_TIMER0] = 1'b1;
        e[RSDC_MOD_TIMER2] = 1'b1;
        e[RSDC_MOD_SYSTEM] = 1'b1;
        e[RSDC_MOD_CPU] = 1'b1;
        e[RSDC_MOD_RSVD34] = 1'b1;
        e[RSDC_MOD_EMU] = 1'b1;
        e[RSDC_MOD_RTC] = 1'b1;
        e[RSDC_MOD_DMA_CC] = (b == 3'h0 || b == 3'h1 || b == 3'h4 || b == 3'h6);
        e[RSDC_MOD_DMA_TC0] = e[RSDC_MOD_DMA_CC];
        e[RSDC_MOD_ASYNC_IF] = (b < 3'h2);
        e[RSDC_MOD_SD0] = (b == 3'h2);
        e[RSDC_MOD_UART0] = (b == 3'h3);
        e[RSDC_MOD_USB] = (b == 3'h4);
        e[RSDC_MOD_SPI0] = (b == 3'h5);
        e[RSDC_MOD_ETH] = (b == 3'h6);
        e[RSDC_MOD_HOST] = (b == 3'h7);
        return e;
    endfunction

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // kind: 1 pin only, 2 pin with test reset, 3 watchdog, 4 emulator max
    task automatic full_reset(input int kind, input logic [2:0] b, input logic [2:0] m);
        rsdc_note_s t;
        @(posedge i_clock);
        want_b <= b;
        want_m <= m;
        sw <= {$random(seed), $random(seed)};
        ext_n <= !(kind <= 2);
        test_n <= (kind != 2);
        wd <= (kind == 3);
        emax <= (kind == 4);
        repeat (3) @(posedge i_clock);
        t.b = b;
        t.m = m;
        t.k = kind == 1 ? RSDC_RST_WARM : kind == 2 ? RSDC_RST_POR : RSDC_RST_MAX;
        t.sw = sw;
        q.push_back(t);
        {ext_n, test_n, wd, emax} <= 4'b1100;
        for (int i = 0; i < 20 && q.size() != 0; i++) @(posedge i_clock);
    endtask

    // one note consumed two edges after each strap capture
    always begin
        @(negedge i_clock);
        if (samp_q === 1'b1 && samp === 1'b0) begin
            @(negedge i_clock);
            if (q.size() == 0) begin
                err_total++;
                $display("[ERR] %0t capture with no pending note", $time);
            end else begin
                n = q.pop_front();
                `CHK(bs, n.b)
                `CHK(ms, n.m)
                `CHK(osc_q, osc)
                `CHK(wide, n.m[2])
                `CHK(last, n.k)
                `CHK(en, exp_en(n.b))
                `CHK(entry, n.b == 3'h1 ? RSDC_FLASH_ENTRY : RSDC_ROM_ENTRY)
                `CHK(apin, n.m[1:0] == 2'h0 ? 16'h0018 : n.m[1:0] == 2'h3 ? 16'h0000 : 16'hffff)
                `CHK(a14, n.m[1:0] == 2'h1)
                `CHK(bsel, {2{n.m[2]}})
                `CHK(hid, {8{n.m[2]}})
                `CHK({upr, up_pin}, 14'h0000)
                `CHK({setup, stb, hold}, {5'h10, 7'h40, 4'h8})
                `CHK({pl1, pl2, byp}, 3'h1)
                `CHK(mrst, n.sw)
                `CHK({por, warm, sys}, 3'h0)
            end
        end
        samp_q = samp;
    end

    initial begin
        repeat (5000) @(posedge i_clock);
        err_total++;
        end_of_test();
    end

    initial begin
        logic [2:0] mt[8];
        mt = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h3, 3'h7};
        osc = $random(seed);
        q.push_back('{3'h0, 3'h0, RSDC_RST_POR, 52'h0});
        repeat (12) @(posedge i_clock);
        i_rst_n <= 1'b1;
        for (int i = 0; i < 20 && q.size() != 0; i++) @(posedge i_clock);
        for (int i = 0; i < 8; i++) full_reset(1 + i % 4, i[2:0], mt[i]);
        repeat (4) full_reset(1 + ($unsigned($random(seed)) % 4), $random(seed), $random(seed));
        @(posedge i_clock);
        esys <= 1'b1;
        want_b <= ~want_b;
        repeat (3) @(negedge i_clock);
        `CHK(sys, 1'b1)
        `CHK(last, RSDC_RST_SYS)
        @(posedge i_clock);
        esys <= 1'b0;
        repeat (3) @(negedge i_clock);
        `CHK({bs, en}, {n.b, exp_en(n.b)})
        end_of_test();
    end
endmodule // tb_reset_strap_default_config
